// file: core/sbbtd_consts.vh
// Constants for the subroutine branch, bit test and module call decoder.
`ifndef SBBTD_CONSTS_VH
`define SBBTD_CONSTS_VH
`define SBBTD_BR_HI 8'h61
`define SBBTD_DISP_WORD 8'h00
`define SBBTD_DISP_LONG 8'hFF
`define SBBTD_BT_DYN_OP 4'h0
`define SBBTD_BT_DYN_MID 3'h4
`define SBBTD_BT_STAT 10'h020
`define SBBTD_CM_OP 10'h01B
`define SBBTD_MODE_DREG 3'h0
`define SBBTD_MODE_AREG 3'h1
`define SBBTD_MODE_EXT 3'h7
`define SBBTD_REG_ABSW 3'h0
`define SBBTD_REG_ABSL 3'h1
`define SBBTD_REG_PCD 3'h2
`define SBBTD_REG_PCX 3'h3
`define SBBTD_REG_IMM 3'h4
`define SBBTD_PTR_STEP 32'h00000004
`define SBBTD_OPC_STEP 32'h00000002
`define SBBTD_SIZE_BYTE 2'h0
`define SBBTD_SIZE_LONG 2'h2
`define SBBTD_FRAME_LONGS 2'h3
`define SBBTD_DESC_LONGS 2'h3
`define SBBTD_DESC_DEPTH 4
`endif

// file: core/sbbtd_desc_mem.v
// Small memory holding the module descriptor words loaded by a module call.
`default_nettype none
module sbbtd_desc_mem (
  input wire core_clk,
  input wire rst,
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [1:0] rd_idx,
  output reg [31:0] rd_data
);
  reg [31:0] mem [0:3];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Read data come out of a register, one cycle after the index.
  always @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

// file: core/sbbtd_decode.v
// Decode and execute logic for subroutine branch, bit test and module call.
`default_nettype none
`include "sbbtd_consts.vh"
module sbbtd_decode (
  input wire core_clk,
  input wire rst,
  input wire op_valid,
  output wire op_ready,
  input wire [15:0] op_word,
  input wire [31:0] op_addr,
  input wire ext_valid,
  output wire ext_ready,
  input wire [15:0] ext_word,
  input wire [31:0] ea_addr,
  input wire [31:0] next_instr_addr,
  input wire [31:0] top_of_stack_pointer,
  input wire [31:0] mod_state_in,
  output wire [2:0] data_reg_sel,
  input wire [31:0] data_reg_n,
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_size,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg ip_load,
  output reg [31:0] instruction_pointer,
  output reg sp_load,
  output reg [31:0] sp_value,
  output reg z_we,
  output reg z_value,
  output reg illegal_op,
  output reg done,
  input wire [1:0] desc_rd_idx,
  output wire [31:0] desc_rd_data
);
  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_DISP_HI = 10'h002;
  localparam [9:0] S_DISP_LO = 10'h004;
  localparam [9:0] S_PUSH = 10'h008;
  localparam [9:0] S_BIT_EXT = 10'h010;
  localparam [9:0] S_BIT_OPND = 10'h020;
  localparam [9:0] S_BIT_IMM = 10'h040;
  localparam [9:0] S_BIT_MEM = 10'h080;
  localparam [9:0] S_CM_EXT = 10'h100;
  localparam [9:0] S_CM_XFER = 10'h200;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions.

  // Data addressing modes; immediate allowed only where asked.
  function ea_data_ok;
    input [2:0] mode;
    input [2:0] rg;
    input allow_imm;
    begin
      if (mode == `SBBTD_MODE_AREG) begin
        ea_data_ok = 1'b0;
      end else if (mode == `SBBTD_MODE_EXT) begin
        ea_data_ok = (rg == `SBBTD_REG_ABSW) || (rg == `SBBTD_REG_ABSL) ||
                     (rg == `SBBTD_REG_PCD) || (rg == `SBBTD_REG_PCX) ||
                     (allow_imm && (rg == `SBBTD_REG_IMM));
      end else begin
        ea_data_ok = 1'b1;
      end
    end
  endfunction

  // Control addressing modes, as used for the module descriptor.
  function ea_ctrl_ok;
    input [2:0] mode;
    input [2:0] rg;
    begin
      case (mode)
        3'h2, 3'h5, 3'h6: ea_ctrl_ok = 1'b1;
        3'h7: ea_ctrl_ok = (rg <= `SBBTD_REG_PCX);
        default: ea_ctrl_ok = 1'b0;
      endcase
    end
  endfunction

  // Selects a bit from a 32-bit operand.
  function pick_bit;
    input [31:0] val;
    input [4:0] num;
    begin
      pick_bit = val[num];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg [9:0] state;
  reg [15:0] op_hold;
  reg [31:0] disp;
  reg [31:0] base_addr;
  reg [31:0] sp_work;
  reg [7:0] bit_num;
  reg [7:0] arg_count;
  reg [1:0] xfer_idx;
  reg xfer_load;
  reg long_disp;
  reg req_sent;

  wire [2:0] op_mode = op_word[5:3];
  wire [2:0] op_reg = op_word[2:0];
  wire is_branch = (op_word[15:8] == `SBBTD_BR_HI);
  wire is_bt_dyn = (op_word[15:12] == `SBBTD_BT_DYN_OP) &&
                   (op_word[8:6] == `SBBTD_BT_DYN_MID);
  wire is_bt_stat = (op_word[15:6] == `SBBTD_BT_STAT);
  wire is_call = (op_word[15:6] == `SBBTD_CM_OP);
  wire take = op_valid && (state == S_IDLE);

  assign op_ready = (state == S_IDLE);
  assign ext_ready = (state == S_DISP_HI) || (state == S_DISP_LO) ||
                     (state == S_BIT_EXT) || (state == S_BIT_IMM) ||
                     (state == S_CM_EXT);
  wire ext_take = ext_valid && ext_ready;
  // While idle the register field names the bit number source.
  assign data_reg_sel = (state == S_IDLE) ? op_word[11:9] : op_hold[2:0];

  wire [31:0] frame_word = (xfer_idx == 2'h0) ? mod_state_in :
                           (xfer_idx == 2'h1) ? next_instr_addr :
                           {24'h000000, arg_count};
  wire [31:0] next_sp = sp_work - `SBBTD_PTR_STEP;
  wire desc_we = (state == S_CM_XFER) && xfer_load && mem_ack;

  sbbtd_desc_mem u_desc (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(desc_we),
    .wr_idx(xfer_idx),
    .wr_data(mem_rdata),
    .rd_idx(desc_rd_idx),
    .rd_data(desc_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always @(posedge core_clk) begin
    if (rst) begin
      state <= S_IDLE;
      op_hold <= 16'h0000;
      disp <= 32'h00000000;
      base_addr <= 32'h00000000;
      sp_work <= 32'h00000000;
      bit_num <= 8'h00;
      arg_count <= 8'h00;
      xfer_idx <= 2'h0;
      xfer_load <= 1'b0;
      long_disp <= 1'b0;
      req_sent <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= `SBBTD_SIZE_BYTE;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      ip_load <= 1'b0;
      instruction_pointer <= 32'h00000000;
      sp_load <= 1'b0;
      sp_value <= 32'h00000000;
      z_we <= 1'b0;
      z_value <= 1'b0;
      illegal_op <= 1'b0;
      done <= 1'b0;
    end else begin
      ip_load <= 1'b0;
      sp_load <= 1'b0;
      z_we <= 1'b0;
      illegal_op <= 1'b0;
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (take) begin
            op_hold <= op_word;
            base_addr <= op_addr + `SBBTD_OPC_STEP;
            sp_work <= top_of_stack_pointer;
            if (is_branch) begin
              long_disp <= (op_word[7:0] == `SBBTD_DISP_LONG);
              if (op_word[7:0] == `SBBTD_DISP_WORD) begin
                // A zero byte never means a short branch.
                state <= S_DISP_LO;
              end else if (op_word[7:0] == `SBBTD_DISP_LONG) begin
                state <= S_DISP_HI;
              end else begin
                disp <= {{24{op_word[7]}}, op_word[7:0]};
                state <= S_PUSH;
              end
            end else if (is_bt_dyn) begin
              if (!ea_data_ok(op_mode, op_reg, 1'b1)) begin
                illegal_op <= 1'b1;
                done <= 1'b1;
              end else begin
                bit_num <= data_reg_n[7:0];
                if (op_mode == `SBBTD_MODE_EXT && op_reg == `SBBTD_REG_IMM) begin
                  state <= S_BIT_IMM;
                end else begin
                  state <= S_BIT_OPND;
                end
              end
            end else if (is_bt_stat) begin
              if (!ea_data_ok(op_mode, op_reg, 1'b0)) begin
                illegal_op <= 1'b1;
                done <= 1'b1;
              end else begin
                state <= S_BIT_EXT;
              end
            end else if (is_call) begin
              if (!ea_ctrl_ok(op_mode, op_reg)) begin
                illegal_op <= 1'b1;
                done <= 1'b1;
              end else begin
                state <= S_CM_EXT;
              end
            end else begin
              illegal_op <= 1'b1;
              done <= 1'b1;
            end
          end
        end
        S_DISP_HI: begin
          if (ext_take) begin
            disp[31:16] <= ext_word;
            state <= S_DISP_LO;
          end
        end
        S_DISP_LO: begin
          if (ext_take) begin
            if (long_disp) begin
              disp[15:0] <= ext_word;
            end else begin
              disp <= {{16{ext_word[15]}}, ext_word};
            end
            state <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (!req_sent) begin
            // Return address is the instruction after all its words.
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= `SBBTD_SIZE_LONG;
            mem_addr <= next_sp;
            mem_wdata <= next_instr_addr;
            req_sent <= 1'b1;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            req_sent <= 1'b0;
            sp_load <= 1'b1;
            sp_value <= next_sp;
            ip_load <= 1'b1;
            instruction_pointer <= base_addr + disp;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_BIT_EXT: begin
          if (ext_take) begin
            bit_num <= ext_word[7:0];
            state <= S_BIT_OPND;
          end
        end
        S_BIT_IMM: begin
          if (ext_take) begin
            z_we <= 1'b1;
            z_value <= ~ext_word[bit_num[2:0]];
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_BIT_OPND: begin
          if (op_hold[5:3] == `SBBTD_MODE_DREG) begin
            z_we <= 1'b1;
            z_value <= ~pick_bit(data_reg_n, bit_num[4:0]);
            done <= 1'b1;
            state <= S_IDLE;
          end else begin
            // Byte read only; the operand is never written back.
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `SBBTD_SIZE_BYTE;
            mem_addr <= ea_addr;
            state <= S_BIT_MEM;
          end
        end
        S_BIT_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            z_we <= 1'b1;
            z_value <= ~pick_bit({24'h000000, mem_rdata[7:0]},
                                 {2'h0, bit_num[2:0]});
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_CM_EXT: begin
          if (ext_take) begin
            arg_count <= ext_word[7:0];
            xfer_idx <= 2'h0;
            xfer_load <= 1'b0;
            state <= S_CM_XFER;
          end
        end
        S_CM_XFER: begin
          if (!req_sent) begin
            mem_req <= 1'b1;
            mem_size <= `SBBTD_SIZE_LONG;
            req_sent <= 1'b1;
            if (!xfer_load) begin
              mem_we <= 1'b1;
              mem_addr <= next_sp;
              mem_wdata <= frame_word;
            end else begin
              mem_we <= 1'b0;
              mem_addr <= ea_addr + {28'h0000000, xfer_idx, 2'h0};
            end
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            req_sent <= 1'b0;
            if (!xfer_load) begin
              sp_work <= next_sp;
              if (xfer_idx == `SBBTD_FRAME_LONGS - 2'h1) begin
                xfer_idx <= 2'h0;
                xfer_load <= 1'b1;
              end else begin
                xfer_idx <= xfer_idx + 2'h1;
              end
            end else if (xfer_idx == `SBBTD_DESC_LONGS - 2'h1) begin
              // Flags are left alone by a module call.
              sp_load <= 1'b1;
              sp_value <= sp_work;
              done <= 1'b1;
              xfer_load <= 1'b0;
              xfer_idx <= 2'h0;
              state <= S_IDLE;
            end else begin
              xfer_idx <= xfer_idx + 2'h1;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/sbbtd_decode_props.sv
// Port assertions for the branch, bit test and module call decoder.
`default_nettype none
module sbbtd_decode_props (
  input wire core_clk,
  input wire rst,
  input wire op_valid,
  input wire op_ready,
  input wire [15:0] op_word,
  input wire [31:0] op_addr,
  input wire [31:0] ea_addr,
  input wire [31:0] next_instr_addr,
  input wire [31:0] top_of_stack_pointer,
  input wire [31:0] data_reg_n,
  input wire mem_req,
  input wire mem_we,
  input wire [1:0] mem_size,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire ip_load,
  input wire [31:0] instruction_pointer,
  input wire sp_load,
  input wire [31:0] sp_value,
  input wire z_we,
  input wire z_value,
  input wire illegal_op,
  input wire done
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = op_valid && op_ready;
  wire is_bt = op_word[15:12] == 4'h0 &&
    (op_word[8:6] == 3'h4 || op_word[11:6] == 6'h20);
  reg [1:0] kind;
  reg [31:0] sp_cap;
  reg [31:0] tgt;
  reg [4:0] bnum;
  //////////////////////////////////////////////////////////////////////////
  // Remembers the class, stack pointer and short target in flight.
  always @(posedge core_clk) begin
    if (rst) begin
      kind <= 2'h0;
    end else if (take) begin
      kind <= op_word[15:8] == 8'h61 ? 2'h1 : is_bt ? 2'h2 :
        op_word[15:6] == 10'h01B ? 2'h3 : 2'h0;
    end else if (done) begin
      kind <= 2'h0;
    end
    if (take) begin
      sp_cap <= top_of_stack_pointer;
      tgt <= op_addr + 32'h2 + {{24{op_word[7]}}, op_word[7:0]};
      bnum <= data_reg_n[4:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_short_br;
    take && op_word[15:8] == 8'h61 && op_word[7:0] != 8'h00 &&
      op_word[7:0] != 8'hFF;
  endsequence
  sequence s_dyn_dreg;
    take && op_word[15:12] == 4'h0 && op_word[8:6] == 3'h4 &&
      op_word[5:3] == 3'h0;
  endsequence
  chk_branch_push: assert property (
    s_short_br |-> ##2 mem_req && mem_we && mem_size == 2'h2 &&
      mem_addr == $past(top_of_stack_pointer, 2) - 32'h4 &&
      mem_wdata == next_instr_addr)
    else $error("branch push wrong");
  chk_short_target: assert property (
    s_short_br |-> ##[2:300] (ip_load && done &&
      instruction_pointer == tgt))
    else $error("short branch target wrong");
  chk_dreg_test: assert property (
    s_dyn_dreg |-> ##2 z_we && done &&
      z_value == !$past(data_reg_n[bnum]))
    else $error("register bit test wrong");
  chk_areg_illegal: assert property (
    take && is_bt && op_word[5:3] == 3'h1 |=> illegal_op && done && !z_we)
    else $error("address register mode accepted");
  chk_static_imm: assert property (
    take && op_word == 16'h083C |=> illegal_op && !z_we)
    else $error("static immediate accepted");
  chk_bt_read_only: assert property (
    kind == 2'h2 && mem_req |-> !mem_we && mem_size == 2'h0 &&
      mem_addr == ea_addr)
    else $error("bit test memory access wrong");
  chk_flags_kept: assert property (
    z_we |-> kind == 2'h2 && done)
    else $error("zero flag written outside bit test");
  chk_frame_write: assert property (
    kind == 2'h3 && mem_req && mem_we |-> mem_size == 2'h2 &&
      (mem_addr == sp_cap - 32'h4 || mem_addr == sp_cap - 32'h8 ||
      mem_addr == sp_cap - 32'hC))
    else $error("frame write address wrong");
  chk_desc_read: assert property (
    kind == 2'h3 && mem_req && !mem_we |-> mem_size == 2'h2 &&
      (mem_addr == ea_addr || mem_addr == ea_addr + 32'h4 ||
      mem_addr == ea_addr + 32'h8))
    else $error("descriptor read address wrong");
  chk_stack_result: assert property (
    sp_load |-> done && sp_value == sp_cap - (kind == 2'h3 ? 32'hC : 32'h4))
    else $error("stack pointer result wrong");
endmodule
bind sbbtd_decode sbbtd_decode_props i_props (
  .core_clk, .rst, .op_valid, .op_ready, .op_word, .op_addr, .ea_addr,
  .next_instr_addr, .top_of_stack_pointer, .data_reg_n, .mem_req, .mem_we,
  .mem_size, .mem_addr, .mem_wdata, .ip_load, .instruction_pointer,
  .sp_load, .sp_value, .z_we, .z_value, .illegal_op, .done);
`default_nettype wire

// file: dv/sbbtd_decode_tb_top.sv
// Self-checking bench for the branch, bit test and module call decoder.
`default_nettype none
module sbbtd_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic ext_valid = 1'b0;
  logic mem_ack = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic [15:0] ext_word = 16'h0000;
  logic [31:0] op_addr = 32'h00001000;
  logic [31:0] ea_addr = 32'h00003004;
  logic [31:0] next_instr_addr = 32'h00001002;
  logic [31:0] top_of_stack_pointer = 32'h00002000;
  logic [31:0] mod_state_in = 32'hCAFE0001;
  logic [31:0] mem_rdata = 32'h00000000;
  logic [1:0] desc_rd_idx = 2'h0;
  logic [31:0] dregs [0:7];
  wire op_ready, ext_ready, mem_req, mem_we, ip_load, sp_load;
  wire z_we, z_value, illegal_op, done;
  wire [2:0] data_reg_sel;
  wire [1:0] mem_size;
  wire [31:0] mem_addr, mem_wdata, instruction_pointer, sp_value;
  wire [31:0] desc_rd_data;
  wire [31:0] data_reg_n = dregs[data_reg_sel];
  int bad_count = 0;
  int checks = 0;
  int lat = 0;
  int cnt = 0;
  int rd_cnt = 0;
  logic [31:0] wa [$];
  logic [31:0] wd [$];
  logic zseen, ill, zv;
  sbbtd_decode i_dut (
    .core_clk, .rst, .op_valid, .op_ready, .op_word, .op_addr, .ext_valid,
    .ext_ready, .ext_word, .ea_addr, .next_instr_addr, .top_of_stack_pointer,
    .mod_state_in, .data_reg_sel, .data_reg_n, .mem_req, .mem_we, .mem_size,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ip_load,
    .instruction_pointer, .sp_load, .sp_value, .z_we, .z_value, .illegal_op,
    .done, .desc_rd_idx, .desc_rd_data);
  always #12.5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////
  // Memory answers after lat idle cycles and logs every write.
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt >= lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr ^ 32'hA5A50000;
        cnt <= 0;
        if (mem_we) begin
          wa.push_back(mem_addr);
          wd.push_back(mem_wdata);
        end else begin
          rd_cnt <= rd_cnt + 1;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("BAD at %0t: wait ran out", $time);
    results();
  endtask
  // Offers an opcode or extension word and holds it until it is taken.
  task automatic hs(input bit ext, input logic [15:0] w);
    int n = 0;
    @(posedge core_clk);
    if (ext) begin
      ext_valid <= 1'b1;
      ext_word <= w;
    end else begin
      op_valid <= 1'b1;
      op_word <= w;
    end
    do begin
      @(negedge core_clk);
      n++;
    end while ((ext ? ext_ready : op_ready) !== 1'b1 && n < 60);
    if (n >= 60) hang();
    @(posedge core_clk);
    ext_valid <= 1'b0;
    op_valid <= 1'b0;
  endtask
  task automatic wait_done;
    int n = 0;
    zseen = 1'b0;
    ill = 1'b0;
    do begin
      @(negedge core_clk);
      n++;
      if (z_we === 1'b1) begin
        zseen = 1'b1;
        zv = z_value;
      end
      if (illegal_op === 1'b1) ill = 1'b1;
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) hang();
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_branch(input logic [15:0] w, input int ne,
      input logic [31:0] disp, input int l);
    logic [31:0] ret;
    ret = op_addr + 32'h2 + 32'(2 * ne);
    @(posedge core_clk);
    next_instr_addr <= ret;
    lat <= l;
    wa.delete();
    wd.delete();
    hs(0, w);
    if (ne == 1) hs(1, disp[15:0]);
    if (ne == 2) hs(1, disp[31:16]);
    if (ne == 2) hs(1, disp[15:0]);
    wait_done();
    chk(ill, 1'b0);
    chk(wa[0], top_of_stack_pointer - 32'h4);
    chk(wd[0], ret);
    chk(sp_value, top_of_stack_pointer - 32'h4);
    chk(instruction_pointer, op_addr + 32'h2 + disp);
  endtask
  task automatic t_bt(input logic [15:0] w, input bit ne,
      input logic [15:0] e, input logic expz, input int rds);
    int r0 = rd_cnt;
    int w0 = wa.size();
    hs(0, w);
    if (ne) hs(1, e);
    wait_done();
    chk(ill, 1'b0);
    chk(zseen, 1'b1);
    chk(zv, expz);
    chk(rd_cnt - r0, rds);
    chk(wa.size() - w0, 0);
  endtask
  task automatic t_bit_tests;
    logic [5:0] modes [9] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38,
      6'h39, 6'h3A, 6'h3B};
    t_bt(16'h0302, 0, 16'h0000, 1'b0, 0);
    t_bt(16'h0303, 0, 16'h0000, 1'b1, 0);
    t_bt(16'h0802, 1, 16'h0027, 1'b1, 0);
    t_bt(16'h0803, 1, 16'h0027, 1'b0, 0);
    t_bt(16'h013C, 1, 16'h0004, 1'b0, 0);
    foreach (modes[i]) begin
      t_bt(16'h0100 | modes[i], 0, 16'h0000, 1'b0, 1);
      t_bt(16'h0800 | modes[i], 1, 16'h000B, 1'b1, 1);
    end
  endtask
  task automatic t_illegal;
    logic [15:0] ops [5] = '{16'h0108, 16'h0808, 16'h083C, 16'h06C0,
      16'h06D8};
    foreach (ops[i]) begin
      hs(0, ops[i]);
      wait_done();
      chk(ill, 1'b1);
      chk(zseen, 1'b0);
    end
  endtask
  task automatic t_mcall;
    int rd0 = rd_cnt;
    wa.delete();
    wd.delete();
    lat <= 3;
    hs(0, 16'h06D0);
    hs(1, 16'h0010);
    wait_done();
    chk(ill, 1'b0);
    chk(zseen, 1'b0);
    chk(sp_value, top_of_stack_pointer - 32'hC);
    chk(wa[0], top_of_stack_pointer - 32'h4);
    chk(wd[0], mod_state_in);
    chk(wa[2], top_of_stack_pointer - 32'hC);
    chk(wd[2], 32'h00000010);
    chk(rd_cnt - rd0, 3);
    for (int n = 0; n < 3; n++) begin
      @(posedge core_clk);
      desc_rd_idx <= n[1:0];
      @(posedge core_clk);
      @(negedge core_clk);
      chk(desc_rd_data, (ea_addr + 32'(4 * n)) ^ 32'hA5A50000);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    dregs = '{32'h0000000A, 32'h00000025, 32'h00000020, 32'hFFFFFFDF,
      32'h0, 32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(op_ready, 1'b1);
    chk(mem_req, 1'b0);
    t_branch(16'h61FC, 0, 32'hFFFFFFFC, 0);
    t_branch(16'h617F, 0, 32'h0000007F, 2);
    t_branch(16'h6100, 1, 32'hFFFF8000, 2);
    t_branch(16'h61FF, 2, 32'h00010000, 1);
    t_bit_tests();
    t_illegal();
    t_mcall();
    results();
  end
endmodule
`default_nettype wire
